// >>> logic/gpio_cd_pkg.sv
// package for the two gpio ports, the first of them shared with oscillator pins
// assumes byte-wide register port with 16-bit byte addresses
`default_nettype none
package gpio_cd_pkg;

	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [15:0] ADDR_PORTC_OUT_LATCH  = 16'h7FD0;
	localparam logic [15:0] ADDR_PORTC_PIN_INPUT  = 16'h7FD1;
	localparam logic [15:0] ADDR_PORTC_DIRECTION  = 16'h7FD2;
	localparam logic [15:0] ADDR_PORTD_OUT_LATCH  = 16'h7FD4;
	localparam logic [15:0] ADDR_PORTD_PIN_INPUT  = 16'h7FD5;
	localparam logic [15:0] ADDR_PORTD_DIRECTION  = 16'h7FD6;
	localparam logic [15:0] ADDR_PORTD_FUNC_SEL   = 16'h7FFD;

	// -----------------------------------------------------------------
	// widths and reset values
	// -----------------------------------------------------------------
	localparam int          PORTC_W     = 5;
	localparam int          PORTD_W     = 6;
	localparam logic [4:0]  PORTC_RST   = 5'h00;
	localparam logic [5:0]  PORTD_RST   = 6'h00;

	// -----------------------------------------------------------------
	// oscillator control bit positions
	// -----------------------------------------------------------------
	localparam int OSC_CRYSTAL_BIT_A = 2;
	localparam int OSC_CRYSTAL_BIT_B = 0;
	localparam int OSC_CERAMIC_BIT_A = 7;
	localparam int OSC_CERAMIC_BIT_B = 3;
	localparam int OSC_CERAMIC_BIT_C = 1;

	// power modes
	typedef enum logic [1:0] {
		PM_RUN   = 2'b00,
		PM_HALT  = 2'b01,
		PM_HOLD  = 2'b10,
		PM_EXT_HOLD = 2'b11
	} power_mode_e;

	// drive of one pin
	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic slow;
	} pin_drive_s;

endpackage

`default_nettype wire

// >>> logic/gpio_cd_ports.sv
// two gpio ports: a 5-pin port shared with oscillator pins and a 6-pin port
// assumes pins arrive asynchronous, power mode and oscillator control are same-clock
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Notes on behaviour
// -----------------------------------------------------------------
// Notes on behaviour
// - first port has five pins, each with its own latch and direction bit.
// - oscillator claim of a pin overrides latch and direction.
// - pins 0,1 crystal mode when control bits 2 and 0 both set.
// - pins 0,1 normal: direction 0 floats, direction 1 drives latch.
// - pin 2 floats, pulls up on latch 1, or drives latch.
// - pins 3,4 ceramic mode when control bits 7,3,1 set, else normal.
// - first port input register reads pin levels in every direction.
// - halt freezes every first-port pin at its entry state except the ceramic mode of pins 3,4.
// - hold keeps output pins; oscillator pins revert to port operation.
// - extended hold keeps crystal and output pins; ceramic pins revert.
// - second port has six pins with latch, direction and function bits.
// - function 0: float, pull-up on latch 1, or drive latch.
// - function 1: slow drive, or low / float-inverted when direction set.
// - inverted-input pins read back the complement of the pin.
// - second port input register reads all six pin levels.
// - halt, hold and extended hold freeze second-port output and pull-up.
// - second-port latch is output data and input pull-up enable.
module gpio_cd_ports
	import gpio_cd_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [15:0]       reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic [7:0]        oscillator_control_reg,
	input  wire power_mode_e       power_mode,
	input  wire logic [PORTC_W-1:0] portc_in,
	output logic      [PORTC_W-1:0] portc_out,
	output logic      [PORTC_W-1:0] portc_oe,
	output logic      [PORTC_W-1:0] portc_pull_up,
	output logic                   crystal_osc_mode,
	output logic                   ceramic_osc_mode,
	input  wire logic [PORTD_W-1:0] portd_in,
	output logic      [PORTD_W-1:0] portd_out,
	output logic      [PORTD_W-1:0] portd_oe,
	output logic      [PORTD_W-1:0] portd_pull_up,
	output logic      [PORTD_W-1:0] portd_slow
);

	// -----------------------------------------------------------------
	// register file
	// -----------------------------------------------------------------
	logic [PORTC_W-1:0] portc_out_latch_r, portc_out_latch_nxt;
	logic [PORTC_W-1:0] portc_direction_r, portc_direction_nxt;
	logic [PORTD_W-1:0] portd_out_latch_r, portd_out_latch_nxt;
	logic [PORTD_W-1:0] portd_direction_r, portd_direction_nxt;
	logic [PORTD_W-1:0] portd_function_select_r, portd_function_select_nxt;
	logic [7:0]         reg_rdata_r, reg_rdata_nxt;

	// synchronised pin levels
	logic [PORTC_W-1:0] pc_meta_r, pc_sync_r;
	logic [PORTD_W-1:0] pd_meta_r, pd_sync_r;

	// frozen drive in low-power modes
	logic [PORTC_W-1:0] pc_out_hold_r, pc_out_hold_nxt;
	logic [PORTC_W-1:0] pc_oe_hold_r, pc_oe_hold_nxt;
	logic [PORTC_W-1:0] pc_pu_hold_r, pc_pu_hold_nxt;
	logic               crystal_hold_r, crystal_hold_nxt;
	logic [PORTD_W-1:0] pd_out_hold_r, pd_out_hold_nxt;
	logic [PORTD_W-1:0] pd_oe_hold_r, pd_oe_hold_nxt;
	logic [PORTD_W-1:0] pd_pu_hold_r, pd_pu_hold_nxt;
	logic [PORTD_W-1:0] pd_slow_hold_r, pd_slow_hold_nxt;
	power_mode_e        mode_prev_r;

	logic               crystal_sel, ceramic_sel;
	logic [PORTC_W-1:0] pc_out_live, pc_oe_live, pc_pu_live;
	logic [PORTD_W-1:0] pd_out_live, pd_oe_live, pd_pu_live, pd_slow_live, pd_inv;
	logic               entering;

	always_comb begin
		portc_out_latch_nxt       = portc_out_latch_r;
		portc_direction_nxt       = portc_direction_r;
		portd_out_latch_nxt       = portd_out_latch_r;
		portd_direction_nxt       = portd_direction_r;
		portd_function_select_nxt = portd_function_select_r;
		if (reg_wr) begin
			// upper bits are dropped by the part-select
			unique case (reg_addr)
				ADDR_PORTC_OUT_LATCH: portc_out_latch_nxt = reg_wdata[PORTC_W-1:0];
				ADDR_PORTC_DIRECTION: portc_direction_nxt = reg_wdata[PORTC_W-1:0];
				ADDR_PORTD_OUT_LATCH: portd_out_latch_nxt = reg_wdata[PORTD_W-1:0];
				ADDR_PORTD_DIRECTION: portd_direction_nxt = reg_wdata[PORTD_W-1:0];
				ADDR_PORTD_FUNC_SEL:  portd_function_select_nxt = reg_wdata[PORTD_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		reg_rdata_nxt = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_PORTC_OUT_LATCH: reg_rdata_nxt = {3'h0, portc_out_latch_r};
				ADDR_PORTC_PIN_INPUT: reg_rdata_nxt = {3'h0, pc_sync_r};
				ADDR_PORTC_DIRECTION: reg_rdata_nxt = {3'h0, portc_direction_r};
				ADDR_PORTD_OUT_LATCH: reg_rdata_nxt = {2'h0, portd_out_latch_r};
				ADDR_PORTD_PIN_INPUT: reg_rdata_nxt = {2'h0, pd_sync_r ^ pd_inv};
				ADDR_PORTD_DIRECTION: reg_rdata_nxt = {2'h0, portd_direction_r};
				ADDR_PORTD_FUNC_SEL:  reg_rdata_nxt = {2'h0, portd_function_select_r};
				default:              reg_rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			portc_out_latch_r       <= PORTC_RST;
			portc_direction_r       <= PORTC_RST;
			portd_out_latch_r       <= PORTD_RST;
			portd_direction_r       <= PORTD_RST;
			portd_function_select_r <= PORTD_RST;
			reg_rdata_r             <= 8'h00;
		end else begin
			portc_out_latch_r       <= portc_out_latch_nxt;
			portc_direction_r       <= portc_direction_nxt;
			portd_out_latch_r       <= portd_out_latch_nxt;
			portd_direction_r       <= portd_direction_nxt;
			portd_function_select_r <= portd_function_select_nxt;
			reg_rdata_r             <= reg_rdata_nxt;
		end
	end
	assign reg_rdata = reg_rdata_r;

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_meta_r <= PORTC_RST;
			pc_sync_r <= PORTC_RST;
			pd_meta_r <= PORTD_RST;
			pd_sync_r <= PORTD_RST;
		end else begin
			pc_meta_r <= portc_in;
			pc_sync_r <= pc_meta_r;
			pd_meta_r <= portd_in;
			pd_sync_r <= pd_meta_r;
		end
	end

	// -----------------------------------------------------------------
	// live pin decode
	// -----------------------------------------------------------------
	assign crystal_sel = oscillator_control_reg[OSC_CRYSTAL_BIT_A]
		& oscillator_control_reg[OSC_CRYSTAL_BIT_B];
	assign ceramic_sel = oscillator_control_reg[OSC_CERAMIC_BIT_A]
		& oscillator_control_reg[OSC_CERAMIC_BIT_B]
		& oscillator_control_reg[OSC_CERAMIC_BIT_C];

	always_comb begin
		pc_out_live = portc_out_latch_r;
		pc_oe_live  = portc_direction_r;
		pc_pu_live  = '0;
		// pin 2 pull-up only; software keeps it floating for the filter
		pc_pu_live[2] = portc_out_latch_r[2] & ~portc_direction_r[2];
		if (crystal_sel) begin
			pc_oe_live[1:0]  = 2'h0;
			pc_out_live[1:0] = 2'h0;
		end
		if (ceramic_sel) begin
			pc_oe_live[4:3]  = 2'h0;
			pc_out_live[4:3] = 2'h0;
		end
	end

	always_comb begin
		for (int i = 0; i < PORTD_W; i++) begin
			pd_out_live[i]  = portd_out_latch_r[i];
			pd_pu_live[i]   = 1'b0;
			pd_slow_live[i] = 1'b0;
			pd_inv[i]       = 1'b0;
			if (!portd_function_select_r[i]) begin
				pd_oe_live[i] = portd_direction_r[i];
				pd_pu_live[i] = portd_out_latch_r[i] & ~portd_direction_r[i];
			end else if (!portd_direction_r[i]) begin
				pd_oe_live[i]   = 1'b1;
				pd_slow_live[i] = 1'b1;
			end else begin
				// open-drain style: latch 1 releases the pin
				pd_oe_live[i]  = ~portd_out_latch_r[i];
				pd_out_live[i] = 1'b0;
				pd_inv[i]      = portd_out_latch_r[i];
			end
		end
	end

	// -----------------------------------------------------------------
	// low-power freeze
	// -----------------------------------------------------------------
	assign entering = (power_mode != PM_RUN) && (mode_prev_r == PM_RUN);

	always_comb begin
		pc_out_hold_nxt  = pc_out_hold_r;
		pc_oe_hold_nxt   = pc_oe_hold_r;
		pc_pu_hold_nxt   = pc_pu_hold_r;
		crystal_hold_nxt = crystal_hold_r;
		pd_out_hold_nxt  = pd_out_hold_r;
		pd_oe_hold_nxt   = pd_oe_hold_r;
		pd_pu_hold_nxt   = pd_pu_hold_r;
		pd_slow_hold_nxt = pd_slow_hold_r;
		if (entering) begin
			pc_out_hold_nxt  = pc_out_live;
			pc_oe_hold_nxt   = pc_oe_live;
			pc_pu_hold_nxt   = pc_pu_live;
			crystal_hold_nxt = crystal_sel;
			pd_out_hold_nxt  = pd_out_live;
			pd_oe_hold_nxt   = pd_oe_live;
			pd_pu_hold_nxt   = pd_pu_live;
			pd_slow_hold_nxt = pd_slow_live;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_out_hold_r  <= PORTC_RST;
			pc_oe_hold_r   <= PORTC_RST;
			pc_pu_hold_r   <= PORTC_RST;
			crystal_hold_r <= 1'b0;
			pd_out_hold_r  <= PORTD_RST;
			pd_oe_hold_r   <= PORTD_RST;
			pd_pu_hold_r   <= PORTD_RST;
			pd_slow_hold_r <= PORTD_RST;
			mode_prev_r    <= PM_RUN;
		end else begin
			pc_out_hold_r  <= pc_out_hold_nxt;
			pc_oe_hold_r   <= pc_oe_hold_nxt;
			pc_pu_hold_r   <= pc_pu_hold_nxt;
			crystal_hold_r <= crystal_hold_nxt;
			pd_out_hold_r  <= pd_out_hold_nxt;
			pd_oe_hold_r   <= pd_oe_hold_nxt;
			pd_pu_hold_r   <= pd_pu_hold_nxt;
			pd_slow_hold_r <= pd_slow_hold_nxt;
			mode_prev_r    <= power_mode;
		end
	end

	// the entry cycle itself still shows live values; freeze starts one edge later
	always_comb begin
		portc_out     = pc_out_live;
		portc_oe      = pc_oe_live;
		portc_pull_up = pc_pu_live;
		crystal_osc_mode = crystal_sel;
		ceramic_osc_mode = ceramic_sel;
		portd_out     = pd_out_live;
		portd_oe      = pd_oe_live;
		portd_pull_up = pd_pu_live;
		portd_slow    = pd_slow_live;
		if (power_mode != PM_RUN && !entering) begin
			portc_out     = pc_out_hold_r;
			portc_oe      = pc_oe_hold_r;
			portc_pull_up = pc_pu_hold_r;
			portd_out     = pd_out_hold_r;
			portd_oe      = pd_oe_hold_r;
			portd_pull_up = pd_pu_hold_r;
			portd_slow    = pd_slow_hold_r;
			crystal_osc_mode = crystal_hold_r;
		end
		// ceramic pins in both holds and crystal pins in hold hand back at once, entry cycle included
		if (power_mode == PM_HOLD || power_mode == PM_EXT_HOLD) begin
			ceramic_osc_mode = 1'b0;
		end
		if (power_mode == PM_HOLD) begin
			crystal_osc_mode = 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	property p_crystal_claim;
		@(posedge mclk) disable iff (rst)
		(crystal_sel && power_mode == PM_RUN) |-> (portc_oe[1:0] == 2'h0);
	endproperty
	a_crystal_claim: assert property (p_crystal_claim) else $error("crystal pins driven");

	property p_ceramic_claim;
		@(posedge mclk) disable iff (rst)
		(ceramic_sel && power_mode == PM_RUN) |-> (portc_oe[4:3] == 2'h0);
	endproperty
	a_ceramic_claim: assert property (p_ceramic_claim) else $error("ceramic pins driven");

	property p_pc2_pull;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_RUN) |->
			(portc_pull_up[2] == (portc_out_latch_r[2] & ~portc_direction_r[2]));
	endproperty
	a_pc2_pull: assert property (p_pc2_pull) else $error("pin 2 pull-up wrong");

	property p_pc_normal;
		@(posedge mclk) disable iff (rst)
		(!crystal_sel && power_mode == PM_RUN) |-> (portc_oe[0] == portc_direction_r[0]);
	endproperty
	a_pc_normal: assert property (p_pc_normal) else $error("pin 0 direction wrong");

	property p_freeze_c;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_HALT && $past(power_mode) == PM_HALT) ##1
			(power_mode == PM_HALT) |-> $stable(portc_out) && $stable(portc_oe);
	endproperty
	a_freeze_c: assert property (p_freeze_c) else $error("first port moved in halt");

	property p_freeze_d;
		@(posedge mclk) disable iff (rst)
		(power_mode != PM_RUN && $past(power_mode) != PM_RUN) ##1
			(power_mode != PM_RUN) |-> $stable(portd_oe) && $stable(portd_pull_up);
	endproperty
	a_freeze_d: assert property (p_freeze_d) else $error("second port moved asleep");

	property p_hold_revert;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_HOLD) |-> !crystal_osc_mode && !ceramic_osc_mode;
	endproperty
	a_hold_revert: assert property (p_hold_revert) else $error("oscillator kept in hold");

	property p_ehold_ceramic;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_EXT_HOLD) |-> !ceramic_osc_mode;
	endproperty
	a_ehold_ceramic: assert property (p_ehold_ceramic) else $error("ceramic kept asleep");

	property p_pd_read;
		@(posedge mclk) disable iff (rst)
		(reg_rd && reg_addr == ADDR_PORTD_PIN_INPUT) |=>
			(reg_rdata == {2'h0, $past(pd_sync_r ^ pd_inv)});
	endproperty
	a_pd_read: assert property (p_pd_read) else $error("second port read wrong");

	property p_upper_zero;
		@(posedge mclk) disable iff (rst)
		(reg_rd && reg_addr == ADDR_PORTC_OUT_LATCH) |=> (reg_rdata[7:5] == 3'h0);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

	property p_pd_func0;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_RUN && !portd_function_select_r[0]) |->
			(portd_oe[0] == portd_direction_r[0]);
	endproperty
	a_pd_func0: assert property (p_pd_func0) else $error("second port pin 0 oe");

	property p_ehold_crystal;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_EXT_HOLD && $past(power_mode) == PM_EXT_HOLD) |->
			$stable(crystal_osc_mode);
	endproperty
	a_ehold_crystal: assert property (p_ehold_crystal) else $error("crystal moved");

	property p_hold_keep_c;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_HOLD && $past(power_mode) == PM_HOLD) |->
			$stable(portc_out) && $stable(portc_oe);
	endproperty
	a_hold_keep_c: assert property (p_hold_keep_c) else $error("first port moved");

	property p_pd_slow;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_RUN && portd_function_select_r[0] && !portd_direction_r[0]) |->
			portd_oe[0] && portd_slow[0] && (portd_out[0] == portd_out_latch_r[0]);
	endproperty
	a_pd_slow: assert property (p_pd_slow) else $error("slow drive wrong");

	property p_pd_open;
		@(posedge mclk) disable iff (rst)
		(power_mode == PM_RUN && portd_function_select_r[0] && portd_direction_r[0]) |->
			(portd_oe[0] == !portd_out_latch_r[0]) && (!portd_oe[0] || !portd_out[0]);
	endproperty
	a_pd_open: assert property (p_pd_open) else $error("open-drain drive wrong");

endmodule // gpio_cd_ports

`default_nettype wire

// >>> sim/pin_far_side.sv
// far-side pin model: external drivers, pull-ups and undriven lines
// assumes one pin group per instance and the block's mclk
`timescale 1ns/1ps
`default_nettype none
module pin_far_side #(
	parameter int W = 5
) (
	input  wire logic         mclk,
	input  wire logic [W-1:0] out,
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] pull_up,
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_en,
	output logic      [W-1:0] lvl
);
	// -----------------------------------------------------------------
	// wire resolution
	// -----------------------------------------------------------------
	logic [W-1:0] float_r = '0;

	// undriven lines wander so a stale level never reads as valid
	always @(posedge mclk) begin
		float_r <= ~float_r;
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe[i]) lvl[i] = out[i];
			else if (ext_en[i]) lvl[i] = ext_val[i];
			else if (pull_up[i]) lvl[i] = 1'b1;
			else lvl[i] = float_r[i];
		end
	end
endmodule // pin_far_side
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the two gpio ports
// assumes pin_far_side models the circuitry on both pin groups
`timescale 1ns/1ps
`default_nettype none
module testbench
	import gpio_cd_pkg::*;
;
	logic mclk, rst, wr, rd, cx, fx;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, osc;
	power_mode_e pm;
	logic [4:0] c_in, c_out, c_oe, c_pu, c_ev, c_ee;
	logic [5:0] d_in, d_out, d_oe, d_pu, d_sl, d_ev, d_ee;
	int fails, n_tests;

	gpio_cd_ports u_dut (.mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .oscillator_control_reg(osc),
		.power_mode(pm), .portc_in(c_in), .portc_out(c_out), .portc_oe(c_oe),
		.portc_pull_up(c_pu), .crystal_osc_mode(cx), .ceramic_osc_mode(fx),
		.portd_in(d_in), .portd_out(d_out), .portd_oe(d_oe), .portd_pull_up(d_pu),
		.portd_slow(d_sl));
	pin_far_side #(.W(5)) u_pc (.mclk(mclk), .out(c_out), .oe(c_oe), .pull_up(c_pu),
		.ext_val(c_ev), .ext_en(c_ee), .lvl(c_in));
	pin_far_side #(.W(6)) u_pd (.mclk(mclk), .out(d_out), .oe(d_oe), .pull_up(d_pu),
		.ext_val(d_ev), .ext_en(d_ee), .lvl(d_in));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// -----------------------------------------------------------------
	// bus and compare tasks
	// -----------------------------------------------------------------
	task automatic finish_test;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic w(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_regs;
		rchk(ADDR_PORTC_OUT_LATCH, 8'h00);
		rchk(ADDR_PORTC_DIRECTION, 8'h00);
		rchk(ADDR_PORTD_OUT_LATCH, 8'h00);
		rchk(ADDR_PORTD_DIRECTION, 8'h00);
		rchk(ADDR_PORTD_FUNC_SEL, 8'h00);
		w(16'h7FD3, 8'hFF);
		rchk(16'h7FD3, 8'h00);
		w(ADDR_PORTC_OUT_LATCH, 8'hFF);
		rchk(ADDR_PORTC_OUT_LATCH, 8'h1F);
		w(ADDR_PORTD_FUNC_SEL, 8'hFF);
		rchk(ADDR_PORTD_FUNC_SEL, 8'h3F);
		w(ADDR_PORTD_FUNC_SEL, 8'h00);
	endtask

	task automatic t_portc;
		w(ADDR_PORTC_OUT_LATCH, 8'h0A);
		w(ADDR_PORTC_DIRECTION, 8'h1F);
		wait_n(4);
		chk({3'h0, c_oe}, 8'h1F);
		chk({3'h0, c_out}, 8'h0A);
		rchk(ADDR_PORTC_PIN_INPUT, 8'h0A);
		// pin 2 pulled up, all others driven from outside
		w(ADDR_PORTC_OUT_LATCH, 8'h07);
		w(ADDR_PORTC_DIRECTION, 8'h00);
		@(posedge mclk);
		c_ev <= 5'h13;
		c_ee <= 5'h1B;
		wait_n(4);
		chk({3'h0, c_oe}, 8'h00);
		chk({3'h0, c_pu}, 8'h04);
		rchk(ADDR_PORTC_PIN_INPUT, 8'h17);
		// filter in use: pin 2 neither pulled up nor driven
		w(ADDR_PORTC_OUT_LATCH, 8'h03);
		wait_n(2);
		chk({3'h0, c_pu | c_oe}, 8'h00);
		@(posedge mclk);
		c_ee <= 5'h00;
	endtask

	task automatic t_osc;
		w(ADDR_PORTC_DIRECTION, 8'h1F);
		@(posedge mclk);
		osc <= 8'h05;
		wait_n(2);
		chk({cx, fx, 1'b0, c_oe}, 8'h9C);
		@(posedge mclk);
		osc <= 8'h8A;
		wait_n(2);
		chk({cx, fx, 1'b0, c_oe}, 8'h47);
		@(posedge mclk);
		osc <= 8'h8C;
		wait_n(2);
		chk({cx, fx, 1'b0, c_oe}, 8'h1F);
		@(posedge mclk);
		osc <= 8'h00;
	endtask

	task automatic t_portd;
		logic fs, lt, dr, oe_e;
		for (int k = 0; k < 8; k++) begin
			{fs, lt, dr} = k[2:0];
			oe_e = dr ? ~(fs & lt) : fs;
			w(ADDR_PORTD_FUNC_SEL, {8{fs}});
			w(ADDR_PORTD_OUT_LATCH, {8{lt}});
			w(ADDR_PORTD_DIRECTION, {8{dr}});
			wait_n(2);
			chk({2'h0, d_oe}, {2'h0, {6{oe_e}}});
			chk({2'h0, d_out & d_oe}, {2'h0, {6{oe_e & lt}}});
			chk({2'h0, d_pu}, {2'h0, {6{~fs & lt & ~dr}}});
			chk({2'h0, d_sl & d_oe}, {2'h0, {6{fs & ~dr}}});
		end
		@(posedge mclk);
		d_ev <= 6'h2A;
		d_ee <= 6'h3F;
		wait_n(4);
		rchk(ADDR_PORTD_PIN_INPUT, 8'h15);
		w(ADDR_PORTD_FUNC_SEL, 8'h00);
		wait_n(4);
		rchk(ADDR_PORTD_PIN_INPUT, 8'h3F);
		w(ADDR_PORTD_DIRECTION, 8'h00);
		wait_n(4);
		rchk(ADDR_PORTD_PIN_INPUT, 8'h2A);
		@(posedge mclk);
		d_ee <= 6'h00;
	endtask

	task automatic t_sleep;
		w(ADDR_PORTC_OUT_LATCH, 8'h0A);
		w(ADDR_PORTD_OUT_LATCH, 8'h15);
		@(posedge mclk);
		pm <= PM_HALT;
		wait_n(3);
		w(ADDR_PORTC_OUT_LATCH, 8'h15);
		w(ADDR_PORTD_OUT_LATCH, 8'h2A);
		wait_n(2);
		chk({3'h0, c_out}, 8'h0A);
		chk({2'h0, d_out}, 8'h15);
		@(posedge mclk);
		pm <= PM_RUN;
		wait_n(3);
		chk({3'h0, c_out}, 8'h15);
		w(ADDR_PORTD_DIRECTION, 8'h00);
		@(posedge mclk);
		osc <= 8'h05;
		pm <= PM_HOLD;
		wait_n(3);
		w(ADDR_PORTD_OUT_LATCH, 8'h00);
		w(ADDR_PORTC_OUT_LATCH, 8'h00);
		wait_n(2);
		chk({cx, fx, 6'h00}, 8'h00);
		chk({2'h0, d_pu}, 8'h2A);
		chk({3'h0, c_oe & 5'h1C}, 8'h1C);
		chk({3'h0, c_out & 5'h1C}, 8'h14);
		@(posedge mclk);
		pm <= PM_RUN;
		osc <= 8'h8F;
		wait_n(2);
		@(posedge mclk);
		pm <= PM_EXT_HOLD;
		wait_n(3);
		chk({cx, fx, 6'h00}, 8'h80);
		@(posedge mclk);
		pm <= PM_RUN;
		osc <= 8'h00;
	endtask

	// -----------------------------------------------------------------
	// main sequence and hang guard
	// -----------------------------------------------------------------
	initial begin
		fails = 0;
		n_tests = 0;
		rst = 1'b1;
		{wr, rd, addr, wdata, osc} = '0;
		pm = PM_RUN;
		{c_ev, c_ee, d_ev, d_ee} = '0;
		wait_n(10);
		rst <= 1'b0;
		t_regs();
		t_portc();
		t_osc();
		t_portd();
		t_sleep();
		finish_test();
	end

	initial begin
		wait_n(20000);
		fails++;
		finish_test();
	end
endmodule // testbench
`default_nettype wire
